// [rtl/smbus_port_pkg.sv]
// Constants, offsets and state encoding of the SMBus register port.
package smbus_port_pkg;
    localparam int          CLK_KHZ       = 40000;
    localparam int          TO_MS         = 25;
    localparam logic [23:0] TO_CYC        = 24'(TO_MS * CLK_KHZ);
    localparam logic [6:0]  ADDR_DEFAULT  = 7'h2e;
    localparam logic [6:0]  ADDR_SEL_LO   = 7'h2c;
    localparam logic [6:0]  ADDR_SEL_HI   = 7'h2d;
    localparam logic [4:0]  ADDR_TOP5     = 5'h0b;
    localparam logic [6:0]  ADDR_ARA      = 7'h0c;
    localparam logic [6:0]  ADDR_GCALL    = 7'h00;
    localparam logic [7:0]  UNDEF_DATA    = 8'h00;
    localparam logic [3:0]  OFS_CTRL      = 4'h0;
    localparam logic [3:0]  OFS_STAT      = 4'h4;
    localparam logic [3:0]  OFS_PTR       = 4'h8;
    localparam int          CTRL_PWM_OUTPUT_2     = 0;
    localparam int          CTRL_TACH_INPUT_3    = 1;
    localparam int          CTRL_IRQ_EN   = 2;
    localparam logic [2:0]  CTRL_RESET    = 3'h0;
    localparam logic [1:0]  SETTLE_DONE   = 2'h3;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_AACK = 3'b011,
        ST_RXB  = 3'b010,
        ST_RACK = 3'b110,
        ST_TXB  = 3'b111,
        ST_TACK = 3'b101,
        ST_IGN  = 3'b100
    } link_state_type;
endpackage

// [rtl/smbus_slave_register_port.sv]
// SMBus slave register port with Avalon-MM control and status registers.
//
// Design decisions made here: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
module smbus_slave_register_port
    import smbus_port_pkg::*;
#(
    parameter logic [23:0] TIMEOUT_CYC = smbus_port_pkg::TO_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_o,
    input  wire logic        addr_en_n_i,
    input  wire logic        addr_sel_i,
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic [31:0]      avs_readdata_o,
    output logic             avs_waitrequest_o,
    output logic [7:0]       reg_addr_o,
    output logic [7:0]       reg_wdata_o,
    output logic             reg_wr_o,
    input  wire logic [7:0]  reg_rdata_i,
    input  wire logic        reg_defined_i,
    input  wire logic        status_any_i,
    output logic             irq_n_o,
    output logic             pwm_output_2_int_n_o,
    output logic             tach_input_3_int_n_o,
    output logic             tach_input_4_dis_o,
    output logic             pwm_output_3_dis_o
);
    import smbus_port_pkg::*;

    logic           scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
    logic           en_m, en_s, sel_m, sel_s;
    logic [1:0]     settle_reg;
    logic           mode_reg, locked_reg;
    logic [6:0]     own_reg;
    link_state_type state_reg;
    logic [2:0]     bit_cnt;
    logic [6:0]     sh_reg;
    logic [7:0]     tx_reg;
    logic [1:0]     idx_reg;
    logic           rd_reg, ara_reg, drv_reg;
    logic [7:0]     ptr_reg;
    logic           pend_reg;
    logic [23:0]    to_cnt;
    logic [2:0]     ctrl_reg;
    logic           wait_reg;
    logic           ara_done;

    // The first stage of each synchroniser feeds only the second.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            scl_d <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            sda_d <= 1'b1;
            en_m  <= 1'b1;
            en_s  <= 1'b1;
            sel_m <= 1'b0;
            sel_s <= 1'b0;
        end else begin
            scl_m <= scl_i;
            scl_s <= scl_m;
            scl_d <= scl_s;
            sda_m <= sda_i;
            sda_s <= sda_m;
            sda_d <= sda_s;
            en_m  <= addr_en_n_i;
            en_s  <= en_m;
            sel_m <= addr_sel_i;
            sel_s <= sel_m;
        end
    end

    logic scl_rise, scl_fall, start_det, stop_det, last_bit, to_hit;
    logic [7:0] byte_in;
    logic [6:0] cand_addr, own_addr;
    logic alert_ok, addr_done, rx_done;

    assign scl_rise  = scl_s & ~scl_d;
    assign scl_fall  = ~scl_s & scl_d;
    assign start_det = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_det  = scl_s & scl_d & ~sda_d & sda_s;
    assign byte_in   = {sh_reg, sda_s};
    assign last_bit  = scl_rise & (bit_cnt == 3'h7);
    assign addr_done = (state_reg == ST_ADDR) & last_bit;
    assign rx_done   = (state_reg == ST_RXB) & last_bit;
    assign to_hit    = (to_cnt == TIMEOUT_CYC);
    assign alert_ok  = ctrl_reg[CTRL_IRQ_EN] & status_any_i;

    function automatic logic [6:0] strap_addr(input logic sel);
        strap_addr = sel ? ADDR_SEL_HI : ADDR_SEL_LO;
    endfunction

    assign cand_addr = mode_reg ? strap_addr(sel_s) : ADDR_DEFAULT;
    assign own_addr  = locked_reg ? own_reg : cand_addr;

    // The enable strap is caught once it has settled through the synchroniser; the select pin stays live until the address is latched.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            settle_reg <= 2'h0;
            mode_reg   <= 1'b0;
        end else if (settle_reg != SETTLE_DONE) begin
            settle_reg <= settle_reg + 2'h1;
            mode_reg   <= ~en_s;
        end
    end

    // Latching guards the selection against glitches seen on the select pin later.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            locked_reg <= 1'b0;
            own_reg    <= ADDR_DEFAULT;
        end else if (addr_done && mode_reg && !locked_reg && byte_in[7:3] == ADDR_TOP5) begin
            locked_reg <= 1'b1;
            own_reg    <= cand_addr;
        end
    end

    // Counts clock-low time while a transfer is open; stretching by other agents counts too.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            to_cnt <= 24'h0;
        end else if (scl_s || state_reg == ST_IDLE || to_hit) begin
            to_cnt <= 24'h0;
        end else begin
            to_cnt <= to_cnt + 24'h1;
        end
    end

    // Link sequencer; SDA only ever pulled low, SCL is never driven.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg <= ST_IDLE;
            bit_cnt   <= 3'h0;
            sh_reg    <= 7'h0;
            tx_reg    <= 8'h0;
            idx_reg   <= 2'h0;
            rd_reg    <= 1'b0;
            ara_reg   <= 1'b0;
            drv_reg   <= 1'b0;
            sda_oe_o  <= 1'b0;
            ara_done  <= 1'b0;
        end else begin
            ara_done <= 1'b0;
            if (to_hit || stop_det) begin
                state_reg <= ST_IDLE;
                sda_oe_o  <= 1'b0;
                drv_reg   <= 1'b0;
            end else if (start_det) begin
                state_reg <= ST_ADDR;
                bit_cnt   <= 3'h0;
                idx_reg   <= 2'h0;
                sda_oe_o  <= 1'b0;
                drv_reg   <= 1'b0;
            end else begin
                if (scl_rise) begin
                    sh_reg  <= byte_in[6:0];
                    bit_cnt <= bit_cnt + 3'h1;
                end
                case (state_reg)
                    ST_ADDR: begin
                        if (last_bit) begin
                            rd_reg  <= byte_in[0];
                            ara_reg <= 1'b0;
                            if (byte_in[7:1] == ADDR_GCALL) begin
                                state_reg <= ST_IGN;
                            end else if (byte_in[7:1] == ADDR_ARA && byte_in[0] && alert_ok) begin
                                state_reg <= ST_AACK;
                                ara_reg   <= 1'b1;
                                tx_reg    <= {own_addr, 1'b1};
                            end else if (byte_in[7:1] == own_addr) begin
                                state_reg <= ST_AACK;
                                tx_reg    <= reg_defined_i ? reg_rdata_i : UNDEF_DATA;
                            end else begin
                                state_reg <= ST_IGN;
                            end
                        end
                    end
                    ST_AACK, ST_RACK: begin
                        if (scl_fall) begin
                            if (!drv_reg) begin
                                drv_reg  <= 1'b1;
                                sda_oe_o <= 1'b1;
                            end else begin
                                drv_reg  <= 1'b0;
                                bit_cnt  <= 3'h0;
                                ara_done <= ara_reg && state_reg == ST_AACK;
                                if (state_reg == ST_AACK && rd_reg) begin
                                    state_reg <= ST_TXB;
                                    sda_oe_o  <= ~tx_reg[7];
                                    tx_reg    <= {tx_reg[6:0], 1'b1};
                                end else begin
                                    state_reg <= ST_RXB;
                                    sda_oe_o  <= 1'b0;
                                end
                            end
                        end
                    end
                    ST_RXB: begin
                        if (rx_done) begin
                            idx_reg <= idx_reg + 2'h1;
                            // A third byte is not a valid format and is refused.
                            state_reg <= (idx_reg == 2'h2) ? ST_IGN : ST_RACK;
                        end
                    end
                    ST_TXB: begin
                        if (last_bit) begin
                            state_reg <= ST_TACK;
                        end else if (scl_fall) begin
                            sda_oe_o <= ~tx_reg[7];
                            tx_reg   <= {tx_reg[6:0], 1'b1};
                        end
                    end
                    ST_TACK: begin
                        if (scl_fall) begin
                            sda_oe_o <= 1'b0;
                        end else if (scl_rise) begin
                            state_reg <= ST_IGN;
                        end
                    end
                    ST_IDLE, ST_IGN: begin
                        sda_oe_o <= 1'b0;
                    end
                    default: begin
                        state_reg <= ST_IDLE;
                        sda_oe_o  <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Pointer persists across transactions; pointer write is kept even if no data follows.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ptr_reg <= 8'h0;
        end else if (!to_hit && !stop_det && !start_det && rx_done && idx_reg == 2'h0) begin
            ptr_reg <= byte_in;
        end
    end

    // Data is held back until STOP, so an aborted write never reaches a register.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pend_reg    <= 1'b0;
            reg_wdata_o <= 8'h0;
            reg_wr_o    <= 1'b0;
        end else begin
            reg_wr_o <= 1'b0;
            if (to_hit || start_det || (rx_done && idx_reg == 2'h2)) begin
                pend_reg <= 1'b0;
            end else if (stop_det) begin
                reg_wr_o <= pend_reg;
                pend_reg <= 1'b0;
            end else if (rx_done && idx_reg == 2'h1) begin
                pend_reg    <= 1'b1;
                reg_wdata_o <= byte_in;
            end
        end
    end

    // Avalon slave: waitrequest for one cycle, answer in the next.
    logic bus_req, bus_take;
    assign bus_req  = avs_read_i | avs_write_i;
    assign bus_take = avs_write_i & ~wait_reg;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wait_reg       <= 1'b1;
            avs_readdata_o <= 32'h0;
        end else begin
            wait_reg <= ~(bus_req & wait_reg);
            if (avs_read_i && wait_reg) begin
                case (avs_address_i)
                    OFS_CTRL: avs_readdata_o <= {29'h0, ctrl_reg};
                    OFS_STAT: avs_readdata_o <= {22'h0, state_reg != ST_IDLE, mode_reg, locked_reg, own_addr};
                    OFS_PTR:  avs_readdata_o <= {24'h0, ptr_reg};
                    default:  avs_readdata_o <= 32'h0;
                endcase
            end
        end
    end

    // A software write setting the enable wins over a same-cycle alert clear.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_reg <= CTRL_RESET;
        end else if (bus_take && avs_address_i == OFS_CTRL && avs_byteenable_i[0]) begin
            ctrl_reg <= avs_writedata_i[2:0];
        end else if (ara_done) begin
            ctrl_reg[CTRL_IRQ_EN] <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            irq_n_o              <= 1'b1;
            pwm_output_2_int_n_o <= 1'b1;
            tach_input_3_int_n_o <= 1'b1;
            tach_input_4_dis_o   <= 1'b0;
            pwm_output_3_dis_o   <= 1'b0;
            sda_o                <= 1'b0;
        end else begin
            irq_n_o              <= ~alert_ok;
            pwm_output_2_int_n_o <= ~(alert_ok & ctrl_reg[CTRL_PWM_OUTPUT_2]);
            tach_input_3_int_n_o <= ~(alert_ok & ctrl_reg[CTRL_TACH_INPUT_3]);
            tach_input_4_dis_o   <= mode_reg;
            pwm_output_3_dis_o   <= mode_reg;
            sda_o                <= 1'b0;
        end
    end

    assign avs_waitrequest_o = wait_reg;
    assign reg_addr_o        = ptr_reg;

    sequence seq_addr_byte;
        addr_done && !to_hit && !stop_det && !start_det;
    endsequence

    sequence seq_ack_start;
        state_reg == ST_AACK && scl_fall && !drv_reg && !to_hit && !stop_det && !start_det;
    endsequence

    chk_gcall_ignored: assert property (@(posedge clk_i) disable iff (!rstn_i)
        seq_addr_byte and byte_in[7:1] == ADDR_GCALL |=> state_reg == ST_IGN)
        else $error("General call was not ignored.");

    chk_foreign_nack: assert property (@(posedge clk_i) disable iff (!rstn_i)
        state_reg == ST_IGN |-> !sda_oe_o)
        else $error("SDA driven while ignoring a transfer.");

    chk_ack_drive: assert property (@(posedge clk_i) disable iff (!rstn_i)
        seq_ack_start |=> sda_oe_o && state_reg == ST_AACK)
        else $error("Address acknowledge not driven.");

    chk_stop_idle: assert property (@(posedge clk_i) disable iff (!rstn_i)
        stop_det && !to_hit |=> state_reg == ST_IDLE ##1 !sda_oe_o)
        else $error("STOP did not return the port to idle.");

    chk_write_on_stop: assert property (@(posedge clk_i) disable iff (!rstn_i)
        reg_wr_o |-> $past(stop_det) && $past(pend_reg))
        else $error("Register write without a completed write transfer.");

    chk_timeout_idle: assert property (@(posedge clk_i) disable iff (!rstn_i)
        to_hit |=> state_reg == ST_IDLE && !sda_oe_o)
        else $error("Clock-low timeout did not release the bus.");

    chk_ara_clear: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ara_done && !bus_take |=> !ctrl_reg[CTRL_IRQ_EN])
        else $error("Alert response did not clear the global enable.");

    chk_ara_gate: assert property (@(posedge clk_i) disable iff (!rstn_i)
        seq_addr_byte and byte_in[7:1] == ADDR_ARA && !alert_ok |=> state_reg == ST_IGN)
        else $error("Alert response acknowledged without an enabled event.");

    chk_irq_level: assert property (@(posedge clk_i) disable iff (!rstn_i)
        alert_ok [*2] |-> !irq_n_o)
        else $error("Interrupt output not asserted for an enabled event.");

    chk_undef_zero: assert property (@(posedge clk_i) disable iff (!rstn_i)
        seq_addr_byte and byte_in[7:1] == own_addr && byte_in[0] && !reg_defined_i |=> tx_reg == UNDEF_DATA)
        else $error("Undefined register read not returning zero.");

    chk_strap_off: assert property (@(posedge clk_i) disable iff (!rstn_i)
        settle_reg == SETTLE_DONE && mode_reg |=> tach_input_4_dis_o && pwm_output_3_dis_o)
        else $error("Strap pins not released from fan functions.");
endmodule

// [verif/smbus_host_model.sv]
// SMBus host model driving the clock and data lines of the port.
`timescale 1ns/1ps
module smbus_host_model (
    input  wire logic clk_i,
    input  wire logic sda_oe_i,
    input  wire logic sda_dat_i,
    output logic      scl_o,
    output logic      sda_o
);
    logic drv = 1'h1;
    // The data line has a pull-up, so a released line reads high.
    assign sda_o = drv & (sda_oe_i ? sda_dat_i : 1'h1);
    initial scl_o = 1'h1;
    task automatic w(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic start();
        w(2);
        drv <= 1'h1;
        w(2);
        scl_o <= 1'h1;
        w(4);
        drv <= 1'h0;
        w(4);
        scl_o <= 1'h0;
    endtask
    task automatic stop();
        w(2);
        drv <= 1'h0;
        w(2);
        scl_o <= 1'h1;
        w(4);
        drv <= 1'h1;
        w(4);
    endtask
    // Data moves only while the clock is low, so no bit looks like a start or stop.
    task automatic xbyte(input logic [7:0] tx, input logic b9, output logic [7:0] rx, output logic ack);
        logic [8:0] s;
        logic [8:0] t;
        t = {tx, b9};
        for (int i = 8; i >= 0; i--) begin
            w(2);
            drv <= t[i];
            w(2);
            scl_o <= 1'h1;
            w(4);
            s[i] = sda_o;
            scl_o <= 1'h0;
        end
        rx = s[8:1];
        ack = ~s[0];
    endtask
endmodule

// [verif/smbus_slave_register_port_bench.sv]
// Bench comparing the SMBus port with a behavioural register file.
`timescale 1ns/1ps
module smbus_slave_register_port_bench;
    import smbus_port_pkg::*;
    logic        clk_i = 1'h0;
    logic        rstn_i = 1'h0;
    logic        en_n = 1'h1;
    logic        sel = 1'h1;
    logic [3:0]  av_a = 4'h0;
    logic        av_r = 1'h0;
    logic        av_w = 1'h0;
    logic [31:0] av_d = 32'h0;
    logic [31:0] av_q;
    logic        av_wait;
    logic [7:0]  r_a;
    logic [7:0]  r_wd;
    logic        r_wr;
    logic        st_any = 1'h0;
    logic        irq_n;
    logic        irq_p2;
    logic        irq_t3;
    logic        dis4;
    logic        dis3;
    logic        scl;
    logic        sda;
    logic        sda_oe;
    logic        sda_q;
    logic [7:0]  mem [256];
    logic [7:0]  em [256];
    logic [31:0] q;
    logic [7:0]  rx;
    logic [3:0]  ak;
    logic [31:0] seed = 32'h1e;
    int          bad_count = 0;
    int          cmp_count = 0;
    int          wr_cnt = 0;
    always #12.5 clk_i = ~clk_i;
    smbus_slave_register_port #(.TIMEOUT_CYC(24'h0007d0)) dut (
        .clk_i(clk_i), .rstn_i(rstn_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_q), .sda_oe_o(sda_oe),
        .addr_en_n_i(en_n), .addr_sel_i(sel), .avs_address_i(av_a), .avs_read_i(av_r),
        .avs_write_i(av_w), .avs_writedata_i(av_d), .avs_byteenable_i(4'hf), .avs_readdata_o(av_q),
        .avs_waitrequest_o(av_wait), .reg_addr_o(r_a), .reg_wdata_o(r_wd), .reg_wr_o(r_wr),
        .reg_rdata_i(mem[r_a]), .reg_defined_i(r_a < 8'h60), .status_any_i(st_any), .irq_n_o(irq_n),
        .pwm_output_2_int_n_o(irq_p2), .tach_input_3_int_n_o(irq_t3), .tach_input_4_dis_o(dis4),
        .pwm_output_3_dis_o(dis3));
    smbus_host_model host (.clk_i(clk_i), .sda_oe_i(sda_oe), .sda_dat_i(sda_q), .scl_o(scl), .sda_o(sda));
    // Register file: locations from 60h up are undefined and ignore writes.
    always @(posedge clk_i) begin
        if (r_wr === 1'h1) begin
            wr_cnt++;
            if (r_a < 8'h60) mem[r_a] <= r_wd;
        end
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [31:0] s, input logic [31:0] e, input string m);
        cmp_count++;
        if (s !== e) begin
            bad_count++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic rst(input logic e, input logic s);
        @(posedge clk_i);
        rstn_i <= 1'h0;
        en_n <= e;
        sel <= s;
        repeat (4) @(posedge clk_i);
        rstn_i <= 1'h1;
        repeat (10) @(posedge clk_i);
    endtask
    // The request stands until the edge at which waitrequest is seen low.
    task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        av_a <= a;
        av_w <= w;
        av_r <= ~w;
        av_d <= d;
        do begin
            @(posedge clk_i);
        end while (av_wait !== 1'h0);
        q = av_q;
        av_r <= 1'h0;
        av_w <= 1'h0;
    endtask
    // Write Byte when n is 2, Send Byte when n is 1, an overlong write when n is 3.
    task automatic sw(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d, input int n);
        logic [7:0] x;
        logic b;
        ak = 4'h0;
        host.start();
        host.xbyte({a, 1'h0}, 1'h1, x, b);
        ak[0] = b;
        for (int i = 1; i <= n; i++) begin
            host.xbyte(i == 1 ? p : d, 1'h1, x, b);
            ak[i] = b;
        end
        host.stop();
        repeat (4) @(posedge clk_i);
    endtask
    // Read Byte with a pointer, Receive Byte without; the host ends with NACK and STOP.
    task automatic sr(input logic [6:0] a, input logic wp, input logic [7:0] p);
        logic [7:0] x;
        logic b;
        if (wp) begin
            host.start();
            host.xbyte({a, 1'h0}, 1'h1, x, b);
            host.xbyte(p, 1'h1, x, b);
        end
        host.start();
        host.xbyte({a, 1'h1}, 1'h1, x, b);
        ak[0] = b;
        host.xbyte(8'hff, 1'h1, rx, b);
        host.stop();
    endtask
    initial begin
        repeat (50000) @(posedge clk_i);
        bad_count++;
        final_report();
    end
    initial begin
        logic [7:0] p;
        int c;
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(xs());
            em[i] = mem[i];
        end
        rst(1'h1, 1'h1);
        av(1'h0, OFS_CTRL, 32'h0);
        chk(q[2:0], CTRL_RESET, "control reset");
        av(1'h0, OFS_STAT, 32'h0);
        chk(q[9:0], {3'h0, ADDR_DEFAULT}, "default address");
        av(1'h0, 4'hc, 32'h0);
        chk(q, 32'h0, "unmapped read");
        chk({dis4, dis3}, 2'h0, "pins kept");
        for (int k = 0; k < 4; k++) begin
            p = 8'(xs() % 32'h80);
            c = wr_cnt;
            q = xs();
            sw(ADDR_DEFAULT, p, q[7:0], 2);
            if (p < 8'h60) em[p] = q[7:0];
            chk(ak[2:0], 3'h7, "write acks");
            chk(wr_cnt - c, 1, "one write");
            sr(ADDR_DEFAULT, 1'h1, p);
            chk(rx, p < 8'h60 ? em[p] : UNDEF_DATA, "read byte");
            p = 8'(xs());
            sw(ADDR_DEFAULT, p, 8'h0, 1);
            chk(wr_cnt - c, 1, "send byte");
            av(1'h0, OFS_PTR, 32'h0);
            chk(q[7:0], p, "pointer");
            repeat (2) begin
                sr(ADDR_DEFAULT, 1'h0, 8'h0);
                chk(rx, p < 8'h60 ? em[p] : UNDEF_DATA, "receive byte");
            end
        end
        c = wr_cnt;
        sw(ADDR_DEFAULT, 8'h10, 8'h5a, 3);
        chk(ak, 4'h7, "overlong write");
        sw(ADDR_GCALL, 8'h10, 8'h5a, 2);
        chk(ak[0], 1'h0, "general call");
        sw(ADDR_SEL_HI, 8'h10, 8'h5a, 2);
        chk(ak[0], 1'h0, "foreign address");
        host.start();
        host.xbyte({ADDR_DEFAULT, 1'h0}, 1'h1, rx, ak[0]);
        host.xbyte(8'h10, 1'h1, rx, ak[0]);
        host.xbyte(8'h5a, 1'h1, rx, ak[0]);
        repeat (2100) @(posedge clk_i);
        chk(sda_oe, 1'h0, "bus released");
        av(1'h0, OFS_STAT, 32'h0);
        chk(q[9], 1'h0, "timeout idle");
        host.stop();
        host.start();
        host.xbyte({ADDR_DEFAULT, 1'h0}, 1'h1, rx, ak[0]);
        host.start();
        host.stop();
        chk(wr_cnt - c, 0, "no stray write");
        sw(ADDR_DEFAULT, 8'h10, 8'h5a, 2);
        chk(ak[2:0], 3'h7, "write after abort");
        av(1'h1, OFS_CTRL, 32'h5);
        sr(ADDR_ARA, 1'h0, 8'h0);
        chk(ak[0], 1'h0, "alert without event");
        st_any <= 1'h1;
        for (int m = 0; m < 2; m++) begin
            av(1'h1, OFS_CTRL, m ? 32'h6 : 32'h5);
            repeat (4) @(posedge clk_i);
            chk({irq_n, irq_p2, irq_t3}, m ? 3'h2 : 3'h1, "alert pins");
            sr(ADDR_ARA, 1'h0, 8'h0);
            chk(ak[0], 1'h1, "alert ack");
            chk(rx[7:1], ADDR_DEFAULT, "alert address");
            av(1'h0, OFS_CTRL, 32'h0);
            chk({q[2:0], irq_n}, m ? 4'h5 : 4'h3, "alert enable cleared");
        end
        for (int s = 0; s < 2; s++) begin
            rst(1'h0, s[0]);
            chk({dis4, dis3}, 2'h3, "strap disables");
            sw(ADDR_DEFAULT, 8'h11, 8'h22, 2);
            chk(ak[0], 1'h0, "default unused");
            sel <= ~sel;
            sw(s ? ADDR_SEL_HI : ADDR_SEL_LO, 8'h11, 8'h22, 2);
            chk(ak[2:0], 3'h7, "strap address");
            av(1'h0, OFS_STAT, 32'h0);
            chk(q[9:0], {3'h3, s ? ADDR_SEL_HI : ADDR_SEL_LO}, "latched address");
        end
        final_report();
    end
endmodule
